/* File: rtl/qbp_pkg.sv */
// package: constants and types for the quasi-bidirectional port block
// Operation
// - port 0 pull-up only during bus ones
// - port 0 general output is open drain
// - latch one on port 0 floats pin
// - bus mode takes over port 0 and 2
// - bus mode: p2 latch kept, p0 ones
// - 16-bit address: port 2 strong ones
// - alternate functions pass only with latch one
// - reset loads every latch with ones
// - port 1 alternate function assignment
// - port 3 alternate function assignment
// - latch at S6P2, pin at S1P1
// - pin reads sampled in state 5
// - falling edge when sample is zero and previous was one
// - read-modify-write reads the latch
// - other reads return sampled pins
// - bit writes rewrite whole latch byte
// - zero-to-one gives two-cycle strong pull-up
// - separate write, read-latch, read-pin strobes
package qbp_pkg;
  localparam int PortW = 8;
  localparam int NumPorts = 4;
  localparam logic [7:0] LatchReset = 8'hff;
  // machine cycle: six states of two phases, one clock each
  localparam int StatesPerCycle = 6;
  localparam logic [2:0] StateLast = 3'h5;
  localparam logic [2:0] StateSample = 3'h4;
  localparam logic [1:0] ForcedHighCycles = 2'h2;
  // port 1 alternate bit positions
  localparam int P1Timer2Count = 0;
  localparam int P1Timer2Trig = 1;
  localparam int P1SerClk = 2;
  localparam int P1SerIn = 3;
  localparam int P1SerOut = 4;
  localparam int P1SerSel = 5;
  // port 3 alternate bit positions
  localparam int P3UsbAttach = 1;
  localparam int P3IrqZero = 2;
  localparam int P3IrqOne = 3;
  localparam int P3TmrZero = 4;
  localparam int P3TmrOne = 5;
  localparam int P3WrStrobe = 6;
  localparam int P3RdStrobe = 7;
  // port indices
  localparam logic [1:0] PortZero = 2'h0;
  localparam logic [1:0] PortOne = 2'h1;
  localparam logic [1:0] PortTwo = 2'h2;
  localparam logic [1:0] PortThree = 2'h3;
  typedef enum logic [0:0] {PhaseOne, PhaseTwo} qbp_phase_t;
endpackage : qbp_pkg

/* File: rtl/qbp_pin_cell.sv */
// one quasi-bidirectional port pin: drive states and synchronised input sample
`timescale 1ns/1ps
`default_nettype none
module qbp_pin_cell
  import qbp_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst, // sync reset, active high
  input wire logic latchBit, // latch value already seen by buffer
  input wire logic altOut, // alternate output level, 1 when unused
  input wire logic ownPullup, // 0 for port 0 style open drain
  input wire logic busMode, // driver owned by address/data bus
  input wire logic busBit, // bus value
  input wire logic busStrong, // bus may drive ones strongly
  input wire logic pinIn, // raw pin level
  input wire logic sampleEn, // state 5 sample strobe
  output logic pinOut, // level driven when enabled
  output logic pinOeN, // low while the pin is driven
  output logic strongUp, // forced_high_drive_state indicator
  output logic weakUp, // weak pull-up active
  output logic sampled // synchronised and state-5 sampled level
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic smp;
    logic prevLvl;
    logic [1:0] fhCnt;
  } qbp_cell_t;
  qbp_cell_t s_q, s_d;
  logic lvl;
  always_comb begin
    s_d = s_q;
    s_d.sync1 = pinIn;
    s_d.sync2 = s_q.sync1;
    if (sampleEn) s_d.smp = s_q.sync2;
    lvl = busMode ? busBit : (latchBit & altOut);
    s_d.prevLvl = lvl;
    // zero-to-one gives a short strong pull-up burst
    if (ownPullup && !busMode && lvl && !s_q.prevLvl) begin
      s_d.fhCnt = ForcedHighCycles;
    end else if (s_q.fhCnt != 2'h0) begin
      s_d.fhCnt = s_q.fhCnt - 2'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '{sync1: 1'b1, sync2: 1'b1, smp: 1'b1, prevLvl: 1'b1, fhCnt: 2'h0};
    end else begin
      s_q <= s_d;
    end
  end
  always_comb begin
    pinOut = 1'b0;
    strongUp = 1'b0;
    weakUp = 1'b0;
    pinOeN = 1'b1;
    if (busMode) begin
      // bus ones use the strong pull-up: port 0 always, port 2 for 16-bit
      pinOut = busBit;
      pinOeN = !(busStrong || !busBit);
      strongUp = busBit & busStrong;
      // 8-bit bus ones on port 2 keep the normal weak pull-up
      weakUp = busBit & ownPullup;
    end else if (!lvl) begin
      pinOeN = 1'b0;
    end else if (ownPullup) begin
      pinOut = 1'b1;
      weakUp = 1'b1;
      strongUp = (s_q.fhCnt != 2'h0);
      pinOeN = !strongUp;
    end // port 0 latch one: float
  end
  assign sampled = s_q.smp;
endmodule : qbp_pin_cell
`default_nettype wire

/* File: rtl/qbp_port_logic.sv */
// four 8-bit port latches, pin drivers, alternate functions and timing
`timescale 1ns/1ps
`default_nettype none
module qbp_port_logic
  import qbp_pkg::*;
(
  input wire logic core_clk, // 40 MHz core clock
  input wire logic rst, // sync reset, active high
  input wire logic [1:0] portSel, // port addressed by the cpu
  input wire logic wrLatch, // write-to-latch strobe
  input wire logic rdLatch, // read-latch strobe (rmw reads)
  input wire logic rdPin, // read-pin strobe
  input wire logic bitWr, // single bit write
  input wire logic [2:0] bitIdx, // bit for single bit write
  input wire logic [7:0] wrData, // internal bus byte or bit in [0]
  output logic [7:0] rdData, // registered read data
  output logic rdValid, // one-cycle pulse with rdData
  input wire logic ext_program_access_pin, // level from pin, external access
  input wire logic fetchExternal, // program counter beyond internal rom
  input wire logic extAccess, // data access cycle in progress
  input wire logic addr16, // access uses 16-bit address
  input wire logic [7:0] addrLow, // multiplexed address/data byte
  input wire logic [7:0] addrHigh, // high address byte
  input wire logic [7:0] p1AltOut, // port 1 alternate outputs, 1 idle
  input wire logic [7:0] p3AltOut, // port 3 alternate outputs, 1 idle
  input wire logic [31:0] pinIn, // raw pins, port n in [8n+7:8n]
  output logic [31:0] pinOut, // levels driven
  output logic [31:0] pinOeN, // low while driving
  output logic [31:0] strongUp, // strong pull-up enabled
  output logic [31:0] weakUp, // weak pull-up enabled
  output logic stateS1P1, // machine cycle start strobe
  output logic timer2_count_input, // gated alternate input
  output logic timer2_trigger_input, // gated alternate input
  output logic serial_clock_in, // gated alternate input
  output logic serial_data_in_pin, // gated alternate input
  output logic serial_select_in, // gated alternate input
  output logic usb_attach_detect, // gated alternate input
  output logic ext_irq_zero, // gated alternate input
  output logic ext_irq_one, // gated alternate input
  output logic timer_zero_count_input, // gated alternate input
  output logic timer_one_count_input, // gated alternate input
  output logic [3:0] edgeFall // per-cycle falling edge of t2, t0, t1, timer2_trigger_input
);
  typedef struct packed {
    logic [2:0] stateNo;
    qbp_phase_t phase;
    logic [3:0][7:0] latch;
    logic [3:0][7:0] outBuf;
    logic pendWr;
    logic [1:0] pendSel;
    logic [7:0] pendData;
    logic [7:0] rdData;
    logic rdValid;
    logic busMode;
    logic [3:0] edgePrev;
    logic [3:0] edgeFall;
    logic [3:0] epSync1;
    logic [3:0] epSync2;
  } qbp_state_t;
  qbp_state_t s_q, s_d;
  logic [31:0] sampledPins;
  logic [31:0] rawSynced;
  logic [7:0] rmwByte;
  logic busNow;
  logic s6p2;
  logic s5Sample;
  logic [3:0] edgeRaw;

  // -------------------------------------------------------------
  // pin cells
  // -------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_cell
      localparam int Pn = gi / 8;
      localparam int Bn = gi % 8;
      logic altLvl;
      logic busBitW;
      if (Pn == 1) begin : g_a1
        assign altLvl = p1AltOut[Bn];
      end else if (Pn == 3) begin : g_a3
        assign altLvl = p3AltOut[Bn];
      end else begin : g_an
        assign altLvl = 1'b1;
      end
      assign busBitW = (Pn == 0) ? addrLow[Bn] : addrHigh[Bn];
      qbp_pin_cell u_cell (
        .clk(core_clk),
        .rst(rst),
        .latchBit(s_q.outBuf[Pn][Bn]),
        .altOut(altLvl),
        .ownPullup(Pn != 0),
        .busMode(s_q.busMode && (Pn == 0 || Pn == 2)),
        .busBit(busBitW),
        .busStrong(Pn == 0 || addr16),
        .pinIn(pinIn[gi]),
        .sampleEn(s5Sample),
        .pinOut(pinOut[gi]),
        .pinOeN(pinOeN[gi]),
        .strongUp(strongUp[gi]),
        .weakUp(weakUp[gi]),
        .sampled(sampledPins[gi])
      );
      assign rawSynced[gi] = sampledPins[gi];
    end
  endgenerate

  // -------------------------------------------------------------
  // machine cycle sequencing and cpu access
  // -------------------------------------------------------------
  assign s6p2 = (s_q.stateNo == StateLast) && (s_q.phase == PhaseTwo);
  assign s5Sample = (s_q.stateNo == StateSample) && (s_q.phase == PhaseTwo);
  assign stateS1P1 = (s_q.stateNo == 3'h0) && (s_q.phase == PhaseOne);
  // bus control comes from the pin only through synchronised state
  assign busNow = fetchExternal || extAccess || s_q.epSync2[0];
  assign rmwByte = s_q.latch[portSel];
  assign edgeRaw = {sampledPins[8 + P1Timer2Trig], sampledPins[24 + P3TmrOne],
                    sampledPins[24 + P3TmrZero], sampledPins[8 + P1Timer2Count]};

  always_comb begin
    s_d = s_q;
    s_d.rdValid = 1'b0;
    if (s_q.phase == PhaseTwo) begin
      s_d.phase = PhaseOne;
      s_d.stateNo = (s_q.stateNo == StateLast) ? 3'h0 : s_q.stateNo + 3'h1;
    end else begin
      s_d.phase = PhaseTwo;
    end
    // write is held until S6P2 of the cycle, then lands in the latch
    if (wrLatch) begin
      s_d.pendWr = 1'b1;
      s_d.pendSel = portSel;
      s_d.pendData = wrData;
      if (bitWr) begin
        s_d.pendData = rmwByte;
        s_d.pendData[bitIdx] = wrData[0];
      end
    end
    if (s6p2 && s_q.pendWr) begin
      s_d.latch[s_q.pendSel] = s_q.pendData;
      s_d.pendWr = wrLatch;
    end
    s_d.busMode = busNow || (s_q.busMode && !stateS1P1);
    if (s_q.busMode) s_d.latch[PortZero] = LatchReset;
    // output buffers copy latches only in phase 1, state 1
    if (stateS1P1) s_d.outBuf = s_q.latch;
    if (rdLatch) begin
      s_d.rdData = s_q.latch[portSel];
      s_d.rdValid = 1'b1;
    end else if (rdPin) begin
      s_d.rdData = rawSynced[8 * portSel +: 8];
      s_d.rdValid = 1'b1;
    end
    // one compare per machine cycle on the state-5 samples
    if (stateS1P1) begin
      s_d.edgePrev = edgeRaw;
      s_d.edgeFall = s_q.edgePrev & ~edgeRaw;
    end else begin
      s_d.edgeFall = 4'h0;
    end
    s_d.epSync1 = {3'h0, ext_program_access_pin};
    s_d.epSync2 = s_q.epSync1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.latch <= {NumPorts{LatchReset}};
      s_q.outBuf <= {NumPorts{LatchReset}};
      s_q.edgePrev <= 4'hf;
    end else begin
      s_q <= s_d;
    end
  end

  // -------------------------------------------------------------
  // alternate inputs: only a latch one opens the path
  // -------------------------------------------------------------
  always_comb begin
    timer2_count_input = sampledPins[8 + P1Timer2Count] & s_q.outBuf[1][P1Timer2Count];
    timer2_trigger_input = sampledPins[8 + P1Timer2Trig] & s_q.outBuf[1][P1Timer2Trig];
    serial_clock_in = sampledPins[8 + P1SerClk] & s_q.outBuf[1][P1SerClk];
    serial_data_in_pin = sampledPins[8 + P1SerIn] & s_q.outBuf[1][P1SerIn];
    serial_select_in = sampledPins[8 + P1SerSel] & s_q.outBuf[1][P1SerSel];
    usb_attach_detect = sampledPins[24 + P3UsbAttach] & s_q.outBuf[3][P3UsbAttach];
    ext_irq_zero = sampledPins[24 + P3IrqZero] & s_q.outBuf[3][P3IrqZero];
    ext_irq_one = sampledPins[24 + P3IrqOne] & s_q.outBuf[3][P3IrqOne];
    timer_zero_count_input = sampledPins[24 + P3TmrZero] & s_q.outBuf[3][P3TmrZero];
    timer_one_count_input = sampledPins[24 + P3TmrOne] & s_q.outBuf[3][P3TmrOne];
  end
  assign rdData = s_q.rdData;
  assign rdValid = s_q.rdValid;
  assign edgeFall = s_q.edgeFall;
endmodule : qbp_port_logic
`default_nettype wire

/* File: tb/qbp_port_logic_asserts.sv */
// checker: pin timing and drive relations of the port block
`timescale 1ns/1ps
`default_nettype none
module qbp_port_logic_asserts (
  input wire logic core_clk, // clock
  input wire logic rst, // sync reset
  input wire logic rdLatch, // read latch strobe
  input wire logic rdPin, // read pin strobe
  input wire logic rdValid, // read answer
  input wire logic extAccess, // data bus cycle
  input wire logic fetchExternal, // external fetch
  input wire logic ext_program_access_pin, // external access pin level
  input wire logic addr16, // 16-bit address
  input wire logic [7:0] p3AltOut, // port 3 alternate outputs
  input wire logic [31:0] pinOut, // driven levels
  input wire logic [31:0] pinOeN, // low while driving
  input wire logic [31:0] strongUp, // strong pull-up
  input wire logic [31:0] weakUp, // weak pull-up
  input wire logic stateS1P1, // cycle start
  input wire logic ext_irq_zero // gated alternate input
);
  // ----------------------------------------
  // helper counters and properties
  // ----------------------------------------
  logic [3:0] idleQ;
  logic [3:0] busQ;
  // bus release waits for a cycle boundary, so port 0 is judged only well after it
  always_ff @(posedge core_clk) begin
    if (rst || extAccess || fetchExternal || ext_program_access_pin) idleQ <= 4'h0;
    else if (idleQ != 4'hf) idleQ <= idleQ + 4'h1;
    if (rst || !((extAccess || fetchExternal) && addr16)) busQ <= 4'h0;
    else if (busQ != 4'hf) busQ <= busQ + 4'h1;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_reset_all_ones: assert property ($fell(rst) |->
    pinOeN[7:0] == 8'hff && weakUp[31:8] == 24'hffffff) else $error("pins wrong after reset");
  a_p0_no_weak: assert property (weakUp[7:0] == 8'h00)
    else $error("port 0 weak pull-up on");
  a_p0_open_drain: assert property (idleQ == 4'hf |->
    ((~pinOeN[7:0] & pinOut[7:0]) | strongUp[7:0]) == 8'h00) else $error("port 0 drives high");
  a_read_answer: assert property ((rdLatch || rdPin) |=> rdValid)
    else $error("read not answered");
  a_no_stray_answer: assert property (!$past(rdLatch || rdPin) |-> !rdValid)
    else $error("answer without read");
  a_cycle_period: assert property (stateS1P1 |=>
    !stateS1P1 [*8] ##1 !stateS1P1 [*3] ##1 stateS1P1) else $error("cycle not 12 clocks");
  a_pins_at_s1p1: assert property ($changed(pinOeN[15:8] | pinOut[15:8]) |->
    $past(stateS1P1) || $past(stateS1P1, 2) || $past(stateS1P1, 3))
    else $error("pin changed off cycle start");
  a_forced_high: assert property ($rose(strongUp[8]) |=> strongUp[8] ##1 !strongUp[8])
    else $error("strong pull-up not two clocks");
  a_alt_gated: assert property (!pinOeN[26] && !pinOut[26] && p3AltOut[2] |->
    !ext_irq_zero) else $error("alternate input passed with latch zero");
  a_p2_strong_ones: assert property (busQ == 4'hf |->
    (pinOut[23:16] & ~pinOeN[23:16] & ~strongUp[23:16]) == 8'h00) else $error("weak bus one");
endmodule // qbp_port_logic_asserts
bind qbp_port_logic qbp_port_logic_asserts chk_u (.core_clk(core_clk), .rst(rst),
  .rdLatch(rdLatch), .rdPin(rdPin), .rdValid(rdValid), .extAccess(extAccess),
  .fetchExternal(fetchExternal), .ext_program_access_pin(ext_program_access_pin),
  .addr16(addr16), .p3AltOut(p3AltOut), .pinOut(pinOut),
  .pinOeN(pinOeN), .strongUp(strongUp), .weakUp(weakUp), .stateS1P1(stateS1P1),
  .ext_irq_zero(ext_irq_zero));
`default_nettype wire

/* File: tb/qbp_pin_model.sv */
// board model: resolves pin levels from port drivers and external sources
`timescale 1ns/1ps
`default_nettype none
module qbp_pin_model (
  input wire logic clk, // clock
  input wire logic [31:0] pinOut, // port drive level
  input wire logic [31:0] pinOeN, // low while port drives
  input wire logic [31:0] weakUp, // weak pull-up
  input wire logic [31:0] strongUp, // strong pull-up
  input wire logic [31:0] extEn, // external source active
  input wire logic [31:0] extVal, // external level
  output logic [31:0] pinLvl // resolved level
);
  // ----------------------------------------
  // resolution
  // ----------------------------------------
  logic tglQ = 1'b0;
  always_ff @(posedge clk) tglQ <= ~tglQ;
  // a floating line toggles so a held value cannot pass for a read
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (!pinOeN[i]) pinLvl[i] = pinOut[i];
      else if (extEn[i]) pinLvl[i] = extVal[i];
      else if (weakUp[i] || strongUp[i]) pinLvl[i] = 1'b1;
      else pinLvl[i] = tglQ;
    end
  end
endmodule // qbp_pin_model
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the port block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module tb_top;
  import qbp_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, wrLatch = 1'b0, rdLatch = 1'b0, rdPin = 1'b0;
  logic bitWr = 1'b0, eap = 1'b0, fetchExternal = 1'b0, extAccess = 1'b0, addr16 = 1'b0;
  logic [1:0] portSel = 2'h0;
  logic [2:0] bitIdx = 3'h0;
  logic [7:0] wrData = 8'h00, addrLow = 8'h00, addrHigh = 8'h00, rdData, lat [4];
  logic [31:0] extEn = 32'h0, extVal = 32'h0, pinLvl, pinOut, pinOeN, strongUp, weakUp;
  logic rdValid, stateS1P1;
  logic [7:0] p3Alt = 8'hff;
  logic [4:0] alt1In, alt3In;
  logic [3:0] edgeFall;
  int fail_count = 0, comparisons = 0, cycles = 0;
  qbp_port_logic dut_u (.core_clk(core_clk), .rst(rst), .portSel(portSel), .wrLatch(wrLatch),
    .rdLatch(rdLatch), .rdPin(rdPin), .bitWr(bitWr), .bitIdx(bitIdx), .wrData(wrData),
    .rdData(rdData), .rdValid(rdValid), .ext_program_access_pin(eap),
    .fetchExternal(fetchExternal), .extAccess(extAccess), .addr16(addr16), .addrLow(addrLow),
    .addrHigh(addrHigh), .p1AltOut(8'hff), .p3AltOut(p3Alt), .pinIn(pinLvl), .pinOut(pinOut),
    .pinOeN(pinOeN), .strongUp(strongUp), .weakUp(weakUp), .stateS1P1(stateS1P1),
    .timer2_count_input(alt1In[0]), .timer2_trigger_input(alt1In[1]),
    .serial_clock_in(alt1In[2]), .serial_data_in_pin(alt1In[3]), .serial_select_in(alt1In[4]),
    .usb_attach_detect(alt3In[0]), .ext_irq_zero(alt3In[1]), .ext_irq_one(alt3In[2]),
    .timer_zero_count_input(alt3In[3]), .timer_one_count_input(alt3In[4]), .edgeFall(edgeFall));
  qbp_pin_model mdl_u (.clk(core_clk), .pinOut(pinOut), .pinOeN(pinOeN), .weakUp(weakUp),
    .strongUp(strongUp), .extEn(extEn), .extVal(extVal), .pinLvl(pinLvl));
  // ----------------------------------------
  // clock, timeout and bus tasks
  // ----------------------------------------
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      stop_test;
    end
  end
  task automatic stop_test;
    if (fail_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic align;
    for (int k = 0; k < 13; k++) begin
      @(posedge core_clk);
      if (stateS1P1 === 1'b1) break;
    end
  endtask
  // writes start at a cycle boundary so the latch lands at this cycle's end
  task automatic wr(logic [1:0] p, logic [7:0] d, logic b, logic [2:0] k);
    align;
    portSel <= p;
    wrData <= d;
    bitWr <= b;
    bitIdx <= k;
    wrLatch <= 1'b1;
    cyc(1);
    wrLatch <= 1'b0;
    align;
    cyc(4);
  endtask
  task automatic rd(logic [1:0] p, logic l, output logic [7:0] r);
    portSel <= p;
    rdLatch <= l;
    rdPin <= ~l;
    cyc(1);
    rdLatch <= 1'b0;
    rdPin <= 1'b0;
    cyc(1);
    `CHK(rdValid, 1'b1)
    r = rdData;
  endtask
  function automatic logic [7:0] exp_pin(logic [7:0] d, logic [7:0] e, logic [7:0] v);
    return d & (v | ~e);
  endfunction
  initial begin
    logic [7:0] r, d, e, v, x;
    logic [1:0] p;
    logic [2:0] k;
    int n, s;
    void'($urandom(14));
    cyc(2);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(2'(i), 1'b1, r);
      `CHK(r, LatchReset)
      lat[i] = LatchReset;
    end
    `CHK(pinOeN[7:0], 8'hff)
    wr(PortOne, 8'h00, 1'b0, 3'h0);
    `CHK(pinOeN[15:8] | pinOut[15:8], 8'h00)
    wr(PortOne, 8'hff, 1'b0, 3'h0);
    for (int i = 0; i < 14; i++) begin
      p = 2'($urandom_range(3));
      d = 8'($urandom);
      e = (p == PortZero) ? 8'hff : 8'($urandom);
      v = 8'($urandom);
      x = exp_pin(d, e, v);
      extEn[8*p +: 8] <= e;
      extVal[8*p +: 8] <= v;
      wr(p, d, 1'b0, 3'h0);
      `CHK(pinOeN[8*p +: 8] | pinOut[8*p +: 8], d)
      if (p == PortZero) `CHK(pinOeN[7:0], d)
      rd(p, 1'b1, r);
      `CHK(r, d)
      cyc(30);
      rd(p, 1'b0, r);
      `CHK(r, x)
      if (p == PortOne) `CHK(alt1In, {x[5], x[3:0]})
      if (p == PortThree) `CHK(alt3In, x[5:1])
      lat[p] = d;
      k = 3'($urandom);
      lat[p][k] = 1'($urandom);
      wr(p, {7'h00, lat[p][k]}, 1'b1, k);
      rd(p, 1'b1, r);
      `CHK(r, lat[p])
    end
    for (int m = 0; m < 3; m++) begin
      d = 8'($urandom);
      v = 8'($urandom);
      wr(PortTwo, d, 1'b0, 3'h0);
      extEn <= 32'h0;
      addrHigh <= v;
      addrLow <= 8'($urandom);
      addr16 <= 1'b1;
      extAccess <= (m == 0);
      fetchExternal <= (m == 1);
      eap <= (m == 2);
      cyc(30);
      `CHK(pinLvl[23:16], v)
      rd(PortZero, 1'b1, r);
      `CHK(r, LatchReset)
      rd(PortTwo, 1'b1, r);
      `CHK(r, d)
      extAccess <= 1'b0;
      fetchExternal <= 1'b0;
      eap <= 1'b0;
      addr16 <= 1'b0;
      cyc(30);
      `CHK(pinOeN[23:16] | pinOut[23:16], d)
    end
    wr(PortThree, 8'hff, 1'b0, 3'h0);
    // write strobe held low by its alternate output while the latch holds one
    p3Alt <= 8'hbf;
    cyc(2);
    `CHK(pinLvl[31:30], 2'h2)
    p3Alt <= 8'hff;
    extEn[28] <= 1'b1;
    extVal[28] <= 1'b1;
    cyc(30); // each level held over two machine cycles
    extVal[28] <= 1'b0;
    n = 0;
    s = 0;
    repeat (36) begin
      cyc(1);
      if (edgeFall[1] === 1'b1) n++;
      if ({edgeFall[3:2], edgeFall[0]} !== 3'h0) s++;
    end
    `CHK(n, 1)
    `CHK(s, 0)
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
